// File: vro_overcurrent.sv
// Voltage-restrained overcurrent stage: pick-up, delay, outputs, events
`timescale 1ns/1ps
`include "vro_defs.svh"
module vro_overcurrent #(
    parameter int TICKS_PER_MS = `VRO_CLK_HZ / 1000000 * `VRO_STAMP_RES_US,
    parameter int CNT_W        = 16
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 sampleValid,
    input  wire logic [15:0]          phaseARmsCurrent,
    input  wire logic [15:0]          phaseBRmsCurrent,
    input  wire logic [15:0]          phaseCRmsCurrent,
    input  wire logic [15:0]          positiveSequenceVoltage,
    input  wire logic                 settingsLoad,
    input  wire logic [15:0]          lowCurrentKneeIn,
    input  wire logic [15:0]          highCurrentKneeIn,
    input  wire logic [15:0]          lowVoltageKneeIn,
    input  wire logic [15:0]          highVoltageKneeIn,
    input  wire vro_pkg::vro_delay_t  delayModeIn,
    input  wire logic [15:0]          operateDelayMsIn,
    input  wire logic [15:0]          idmtMultIn,
    input  wire logic [2:0]           activeGroup,
    input  wire logic                 blockIn,
    input  wire logic                 stageForcingEnable,
    input  wire vro_pkg::vro_force_t  stageStatusOverride,
    input  wire logic                 counterClear,
    input  wire logic [3:0]           recReadIndex,
    output logic                      startOut,
    output logic                      tripOut,
    output logic                      blockedOut,
    output logic [2:0]                eventOn,
    output logic [2:0]                eventOff,
    output logic [31:0]               eventStamp,
    output logic [CNT_W-1:0]          startCount,
    output logic [CNT_W-1:0]          tripCount,
    output logic [CNT_W-1:0]          blockedCount,
    output logic [15:0]               pickupLevelNow,
    output logic [15:0]               ratioNow,
    output logic [15:0]               prefaultCurrent,
    output logic                      restrainedMode,
    output logic [101:0]              recReadData
);
    import vro_pkg::*;

    localparam int HIST_N = `VRO_PREFAULT_MS / `VRO_CYCLE_MS;
    localparam int REC_W  = 102;

    vro_rec_if #(.REC_W(REC_W), .AW(4)) rec ();

    vro_record_mem #(.DEPTH(`VRO_REC_DEPTH)) u_mem (
        .sys_clk (sys_clk),
        .rec     (rec)
    );

    // Linear pick-up between the voltage knees; assumes high knee >= low knee
    function automatic logic [15:0] kneeLevel(
        input logic [15:0] u, input logic [15:0] lv, input logic [15:0] hv,
        input logic [15:0] li, input logic [15:0] hi);
        logic [31:0] span;
        span = 32'(hi - li) * 32'(u - lv) / 32'(hv - lv);
        if (hv == lv)
            kneeLevel = (u < lv) ? li : hi; // RULE2 RULE24
        else if (u <= lv)
            kneeLevel = li; // RULE23
        else if (u >= hv)
            kneeLevel = hi; // RULE23
        else
            kneeLevel = li + span[15:0]; // RULE1 RULE23
    endfunction

    // Current over pick-up in hundredths, saturated to 16 bits
    function automatic logic [15:0] ratioOf(input logic [15:0] i, input logic [15:0] p);
        logic [31:0] r;
        r = (32'(i) * `VRO_RATIO_UNIT) / 32'(p);
        ratioOf = (r > 32'h0000ffff) ? 16'hffff : r[15:0];
    endfunction

    // Inverse-time target, never shorter than the set minimum
    function automatic logic [15:0] idmtTarget(
        input logic [15:0] ratio, input logic [15:0] k, input logic [15:0] tmin);
        logic [31:0] t;
        if (ratio <= 16'(`VRO_RATIO_UNIT))
            t = 32'h0000ffff;
        else
            t = (32'(k) * `VRO_RATIO_UNIT) / 32'(ratio - 16'(`VRO_RATIO_UNIT));
        if (t > 32'h0000ffff)
            t = 32'h0000ffff;
        idmtTarget = (t[15:0] < tmin) ? tmin : t[15:0];
    endfunction

    // Settings not switched by activeGroup, reloaded only by settingsLoad
    logic [15:0] lckQ, hckQ, lvkQ, hvkQ, dlyQ, idmtQ;
    vro_delay_t  modeQ;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lckQ  <= `VRO_LCK_RST; // RULE17
            hckQ  <= `VRO_HCK_RST; // RULE17
            lvkQ  <= `VRO_LVK_RST; // RULE18
            hvkQ  <= `VRO_HVK_RST; // RULE18
            dlyQ  <= `VRO_DLY_RST;
            idmtQ <= `VRO_IDMT_RST;
            modeQ <= DLY_DT;
        end
        else if (settingsLoad)
        begin
            lckQ  <= lowCurrentKneeIn;
            hckQ  <= highCurrentKneeIn;
            lvkQ  <= lowVoltageKneeIn;
            hvkQ  <= highVoltageKneeIn;
            dlyQ  <= operateDelayMsIn;
            idmtQ <= idmtMultIn;
            modeQ <= delayModeIn; // RULE4
        end
    end

    // Millisecond time base for stamps and delay counting
    logic [15:0] tickQ;
    logic [31:0] msQ;
    logic        msTick;
    assign msTick = (tickQ == 16'(TICKS_PER_MS - 1));
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tickQ <= 16'h0000;
            msQ   <= 32'h00000000;
        end
        else if (msTick)
        begin
            tickQ <= 16'h0000;
            msQ   <= msQ + 32'h00000001; // RULE8
        end
        else
            tickQ <= tickQ + 16'h0001;
    end

    // Input magnitude processing and saturation check on the 5 ms sample
    logic [15:0] curQ [3];
    logic [15:0] voltQ;
    logic        satQ, evalQ;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            curQ  <= '{16'h0000, 16'h0000, 16'h0000};
            voltQ <= 16'h0000;
            satQ  <= 1'b0;
            evalQ <= 1'b0;
        end
        else
        begin
            evalQ <= sampleValid; // RULE6 RULE11
            if (sampleValid)
            begin
                curQ  <= '{phaseARmsCurrent, phaseBRmsCurrent, phaseCRmsCurrent}; // RULE7
                voltQ <= positiveSequenceVoltage;
                satQ  <= (phaseARmsCurrent == `VRO_SAT_LIMIT) ||
                         (phaseBRmsCurrent == `VRO_SAT_LIMIT) ||
                         (phaseCRmsCurrent == `VRO_SAT_LIMIT);
            end
        end
    end

    // Threshold comparison against the present pick-up level
    logic [15:0] pickNow, maxI, maxRatio, targetMs;
    logic [31:0] dropLvl;
    logic        pickHit, pickHold;
    always_comb
    begin
        pickNow  = kneeLevel(voltQ, lvkQ, hvkQ, lckQ, hckQ); // RULE3
        if (pickNow == 16'h0000)
            pickNow = 16'h0001;
        dropLvl  = 32'(pickNow) * `VRO_DROP_PCT;
        maxI     = 16'h0000;
        maxRatio = 16'h0000;
        pickHit  = satQ;
        pickHold = satQ;
        for (int p = 0; p < 3; p++)
        begin
            if (ratioOf(curQ[p], pickNow) > maxRatio)
                maxRatio = ratioOf(curQ[p], pickNow); // RULE15
            if (curQ[p] > maxI)
                maxI = curQ[p];
            if (curQ[p] > pickNow)
                pickHit = 1'b1;
            if (32'(curQ[p]) * `VRO_RATIO_UNIT >= dropLvl)
                pickHold = 1'b1; // RULE16
        end
        if (modeQ == DLY_IDMT)
            targetMs = idmtTarget(maxRatio, idmtQ, dlyQ); // RULE5
        else
            targetMs = dlyQ; // RULE4
    end

    // Elapsed operate time in ms while started
    vro_state_t  stateQ, stateD;
    logic [15:0] elapsedQ;
    logic        tripReady;
    assign tripReady = (elapsedQ >= targetMs);

    always_comb
    begin
        stateD = stateQ;
        if (evalQ)
        begin
            case (stateQ)
                ST_IDLE:
                    if (pickHit)
                    begin
                        if (blockIn)
                            stateD = ST_BLOCKED; // RULE20
                        else if (targetMs == 16'h0000)
                            stateD = ST_TRIP; // RULE9
                        else
                            stateD = ST_START; // RULE19
                    end
                ST_START:
                    if (!pickHold)
                        stateD = ST_IDLE;
                    else if (blockIn)
                        stateD = ST_BLOCKED; // RULE20
                    else if (tripReady)
                        stateD = ST_TRIP;
                ST_TRIP:
                    if (!pickHold)
                        stateD = ST_IDLE;
                    else if (blockIn)
                        stateD = ST_BLOCKED; // RULE19
                ST_BLOCKED:
                    if (!pickHold)
                        stateD = ST_IDLE;
                    else if (!blockIn)
                        stateD = ST_START;
                default:
                    stateD = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            stateQ <= ST_IDLE;
        else
            stateQ <= stateD;
    end

    // Leaving start resets the delay just as a pick-up release does
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            elapsedQ <= 16'h0000;
        else if (stateD != ST_START)
            elapsedQ <= 16'h0000; // RULE20
        else if (msTick && elapsedQ != 16'hffff)
            elapsedQ <= elapsedQ + 16'h0001;
    end

    // Pre-fault average over the last four 5 ms samples
    logic [15:0] histQ [HIST_N];
    logic [17:0] histSum;
    always_comb
    begin
        histSum = 18'h00000;
        for (int h = 0; h < HIST_N; h++)
            histSum = histSum + 18'(histQ[h]);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int h = 0; h < HIST_N; h++)
                histQ[h] <= 16'h0000;
            prefaultCurrent <= 16'h0000;
        end
        else if (evalQ)
        begin
            prefaultCurrent <= histSum[17:2]; // RULE12
            histQ[0] <= maxI;
            for (int h = 1; h < HIST_N; h++)
                histQ[h] <= histQ[h-1];
        end
    end

    // Output processing; override codes are static and group-independent
    logic       forceOn;
    logic [2:0] outsD, outsQ;
    assign forceOn = stageForcingEnable && (stageStatusOverride != FORCE_NORMAL); // RULE13 RULE14
    always_comb
    begin
        if (forceOn)
        begin
            case (stageStatusOverride)
                FORCE_START:   outsD = 3'b001;
                FORCE_TRIP:    outsD = 3'b011;
                FORCE_BLOCKED: outsD = 3'b100;
                default:       outsD = 3'b000;
            endcase // RULE13
        end
        else
            outsD = {stateQ == ST_BLOCKED, stateQ == ST_TRIP,
                     (stateQ == ST_START) || (stateQ == ST_TRIP)};
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outsQ      <= 3'b000;
            eventOn    <= 3'b000;
            eventOff   <= 3'b000;
            eventStamp <= 32'h00000000;
        end
        else
        begin
            outsQ      <= outsD;
            eventOn    <= outsD & ~outsQ; // RULE8 RULE9
            eventOff   <= ~outsD & outsQ; // RULE8
            eventStamp <= msQ;
        end
    end
    assign {blockedOut, tripOut, startOut} = outsQ;

    // Clear and count in one cycle: the count survives as one
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            startCount   <= '0;
            tripCount    <= '0;
            blockedCount <= '0;
        end
        else
        begin
            startCount   <= (counterClear ? '0 : startCount) + CNT_W'(eventOn[0]); // RULE10
            tripCount    <= (counterClear ? '0 : tripCount) + CNT_W'(eventOn[1]);
            blockedCount <= (counterClear ? '0 : blockedCount) + CNT_W'(eventOn[2]);
        end
    end

    // Display values: pick-up and ratio captured on each evaluated sample, restrainedMode every cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pickupLevelNow <= 16'h0000;
            ratioNow       <= 16'h0000;
            restrainedMode <= 1'b0;
        end
        else
        begin
            restrainedMode <= (hvkQ > lvkQ); // RULE1
            if (evalQ)
            begin
                pickupLevelNow <= pickNow;
                ratioNow       <= maxRatio;
            end
        end
    end

    // Ring of the last twelve on-event records
    logic [3:0] wrPtrQ;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            wrPtrQ <= 4'h0;
        else if (|eventOn)
            wrPtrQ <= (wrPtrQ == 4'(`VRO_REC_DEPTH - 1)) ? 4'h0 : wrPtrQ + 4'h1; // RULE22
    end

    assign rec.wrEn   = |eventOn;
    assign rec.wrAddr = wrPtrQ;
    assign rec.wrData = {eventOn, eventStamp, pickupLevelNow, ratioNow,
                         voltQ, prefaultCurrent, activeGroup};
    assign rec.rdAddr = recReadIndex;
    assign recReadData = rec.rdData;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    chk_trip_with_start: assert property (tripOut |-> startOut) // RULE9
        else $error("trip without start");
    chk_block_no_start: assert property (blockedOut |-> !startOut) // RULE19
        else $error("start while blocked");
    chk_restrained_range: assert property (evalQ && hvkQ > lvkQ && voltQ > hvkQ // RULE23
        |=> pickupLevelNow == $past(hckQ))
        else $error("pick-up not at high knee");
    chk_controlled_step: assert property (evalQ && hvkQ == lvkQ && voltQ < lvkQ // RULE24
        && lckQ != 16'h0000 |=> pickupLevelNow == $past(lckQ))
        else $error("controlled pick-up wrong");
    chk_hold_above_drop: assert property (evalQ && stateQ == ST_START && pickHold // RULE16
        && !blockIn && !tripReady |=> stateQ == ST_START)
        else $error("start dropped above reset level");
    chk_instant_pair: assert property (evalQ && stateQ == ST_IDLE && pickHit // RULE9
        && !blockIn && targetMs == 16'h0000 && !forceOn ##1 !forceOn
        |=> eventOn == 3'b011)
        else $error("instant start and trip apart");
    chk_block_entry: assert property (evalQ && stateQ == ST_START && pickHold // RULE20
        && blockIn |=> stateQ == ST_BLOCKED ##0 elapsedQ == 16'h0000)
        else $error("block did not reset start");
    chk_trip_count: assert property (!counterClear && eventOn[1] // RULE10
        |=> tripCount == $past(tripCount) + CNT_W'(1))
        else $error("trip counter missed event");
    chk_record_ptr: assert property (|eventOn && wrPtrQ == 4'hb // RULE22
        |=> wrPtrQ == 4'h0)
        else $error("record ring did not wrap");
endmodule

// File: vro_defs.svh
// Constants for the voltage-restrained overcurrent stage
// Summary of operation
// RULE1: High knee above low knee: restrained mode
// RULE2: Equal voltage knees: voltage-controlled stepped mode
// RULE3: Pick-up level from voltage and knees
// RULE4: Delay selectable definite or inverse time
// RULE5: Inverse delay from ratio to present pick-up
// RULE6: Fixed per-cycle processing order
// RULE7: All three phase currents evaluated
// RULE8: Three outputs, on/off events, 1 ms stamps
// RULE9: Instant mode: start and trip share stamp
// RULE10: Resettable start, trip, blocked counters
// RULE11: Phase RMS and voltage on 5 ms base
// RULE12: Keep 20 ms average for pre-fault record
// RULE13: Static status override when forcing enabled
// RULE14: General settings ignore setting group switching
// RULE15: Per-phase current to pick-up ratio each cycle
// RULE16: Drop out below 97 percent of pick-up
// RULE17: Current knees 0.01 steps, defaults 0.2/1.2
// RULE18: Voltage knees 0.01 percent, defaults 20/100
// RULE19: Start only while no blocking active
// RULE20: Block at pick-up gives blocked; start resets
// RULE21: Block input arrives 5 ms before delay
// RULE22: Keep last twelve on-event records
// RULE23: Restrained: clamp at knees, interpolate between
// RULE24: Controlled: low knee below voltage knee
`ifndef VRO_DEFS_SVH
`define VRO_DEFS_SVH
`define VRO_CLK_HZ        40000000
`define VRO_STAMP_RES_US  1000
`define VRO_CYCLE_MS      5
`define VRO_PREFAULT_MS   20
`define VRO_BLOCK_LEAD_MS 5
`define VRO_DROP_PCT      97
`define VRO_RATIO_UNIT    100
`define VRO_LCK_RST       16'h0014
`define VRO_HCK_RST       16'h0078
`define VRO_LVK_RST       16'h07d0
`define VRO_HVK_RST       16'h2710
`define VRO_DLY_RST       16'h0064
`define VRO_IDMT_RST      16'h0064
`define VRO_SAT_LIMIT     16'hffff
`define VRO_REC_DEPTH     12
`endif

// File: vro_pkg.sv
// Types shared by the overcurrent stage modules
package vro_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_TRIP, ST_BLOCKED} vro_state_t;
    typedef enum logic {DLY_DT, DLY_IDMT} vro_delay_t;
    typedef enum logic [1:0] {FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED} vro_force_t;
endpackage

// File: vro_rec_if.sv
// Carrier between the stage and its event record memory
`timescale 1ns/1ps
interface vro_rec_if #(parameter int REC_W = 102, parameter int AW = 4);
    logic             wrEn;
    logic [AW-1:0]    wrAddr;
    logic [REC_W-1:0] wrData;
    logic [AW-1:0]    rdAddr;
    logic [REC_W-1:0] rdData;
    modport stage (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
    modport mem   (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// File: vro_record_mem.sv
// Event record store with registered read data
`timescale 1ns/1ps
module vro_record_mem #(
    parameter int DEPTH = 12
) (
    input wire logic sys_clk,
    vro_rec_if.mem   rec
);
    logic [$bits(rec.wrData)-1:0] memQ [DEPTH];

    always_ff @(posedge sys_clk)
    begin
        if (rec.wrEn)
            memQ[rec.wrAddr] <= rec.wrData; // RULE22
    end

    // Out-of-range index reads the first slot
    always_ff @(posedge sys_clk)
    begin
        if (int'(rec.rdAddr) < DEPTH)
            rec.rdData <= memQ[rec.rdAddr];
        else
            rec.rdData <= memQ[0];
    end
endmodule

// File: vro_front_end.sv
// Model of the measurement front end and the blocking source
`timescale 1ns/1ps
module vro_front_end #(
    parameter int PERIOD = 20
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] aSet,
    input  wire logic [15:0] bSet,
    input  wire logic [15:0] cSet,
    input  wire logic [15:0] uSet,
    input  wire logic        blockReq,
    output logic             sampleValid,
    output logic [15:0]      phaseA,
    output logic [15:0]      phaseB,
    output logic [15:0]      phaseC,
    output logic [15:0]      voltage,
    output logic             blockIn
);
    int cnt;
    // One sample per period, none while reset is low
    always @(negedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt <= 0;
            sampleValid <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            sampleValid <= (cnt == PERIOD - 1);
        end
    end
    // Junk outside the sample cycle so a stray read is caught
    assign phaseA  = sampleValid ? aSet : ~aSet;
    assign phaseB  = sampleValid ? bSet : ~bSet;
    assign phaseC  = sampleValid ? cSet : ~cSet;
    assign voltage = sampleValid ? uSet : ~uSet;
    // Bench raises the request well ahead of the delay
    assign blockIn = blockReq;
endmodule

// File: vro_overcurrent_tb.sv
// Self-checking bench for the overcurrent stage
`timescale 1ns/1ps
module vro_overcurrent_tb;
    import vro_pkg::*;
    logic        sys_clk, reset_n, settingsLoad, blk, forceEn, cntClr;
    logic        sampleValid, blockIn, startOut, tripOut, blockedOut, restrainedMode;
    logic [15:0] aS, bS, cS, uS, lc, hc, lv, hv, dly, mult, pA, pB, pC, vU;
    logic [15:0] pickupLevelNow, ratioNow, prefaultCurrent, startCount, tripCount, blockedCount;
    logic [2:0]  grp, eventOn, eventOff, b;
    logic [3:0]  rdIdx;
    logic [31:0] eventStamp, s0, s1;
    logic [101:0] recReadData;
    vro_delay_t  md;
    vro_force_t  ovr;
    int          errTotal, checked, cyc, c0, c1;

    vro_front_end u_vro_front_end (.sys_clk(sys_clk), .reset_n(reset_n), .aSet(aS), .bSet(bS),
        .cSet(cS), .uSet(uS), .blockReq(blk), .sampleValid(sampleValid), .phaseA(pA),
        .phaseB(pB), .phaseC(pC), .voltage(vU), .blockIn(blockIn));

    vro_overcurrent #(.TICKS_PER_MS(4)) u_vro_overcurrent (.sys_clk(sys_clk),
        .reset_n(reset_n), .sampleValid(sampleValid), .phaseARmsCurrent(pA),
        .phaseBRmsCurrent(pB), .phaseCRmsCurrent(pC), .positiveSequenceVoltage(vU),
        .settingsLoad(settingsLoad), .lowCurrentKneeIn(lc), .highCurrentKneeIn(hc),
        .lowVoltageKneeIn(lv), .highVoltageKneeIn(hv), .delayModeIn(md),
        .operateDelayMsIn(dly), .idmtMultIn(mult), .activeGroup(grp), .blockIn(blockIn),
        .stageForcingEnable(forceEn), .stageStatusOverride(ovr), .counterClear(cntClr),
        .recReadIndex(rdIdx), .startOut(startOut), .tripOut(tripOut),
        .blockedOut(blockedOut), .eventOn(eventOn), .eventOff(eventOff),
        .eventStamp(eventStamp), .startCount(startCount), .tripCount(tripCount),
        .blockedCount(blockedCount), .pickupLevelNow(pickupLevelNow), .ratioNow(ratioNow),
        .prefaultCurrent(prefaultCurrent), .restrainedMode(restrainedMode),
        .recReadData(recReadData));

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task giveVerdict;
        $display("checks %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Ceiling well above the few thousand cycles the tests need
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errTotal++;
            $display("ERROR t=%0t run hung", $time);
            giveVerdict;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("ERROR t=%0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task smp(input int n);
        repeat (n) @(posedge sampleValid);
        repeat (4) @(negedge sys_clk);
    endtask

    task load(input logic [15:0] l1, h1, l2, h2, input vro_delay_t m, input logic [15:0] d);
        @(negedge sys_clk);
        {lc, hc, lv, hv, dly, settingsLoad} = {l1, h1, l2, h2, d, 1'b1};
        md = m;
        @(negedge sys_clk);
        settingsLoad = 1'b0;
    endtask

    // Bounded wait for any on-event pulse
    task waitOn;
        b = 3'b000;
        repeat (3000)
            if (b === 3'b000)
            begin
                @(negedge sys_clk);
                b = eventOn;
                s1 = eventStamp;
            end
        c1 = cyc;
    endtask

    task idle;
        {aS, bS, cS, blk} = '0;
        smp(3);
    endtask

    task pk(input logic [15:0] u, input logic [15:0] e);
        uS = u;
        smp(1);
        chk(pickupLevelNow, e, "pickup");
    endtask

    task t_pick;
        chk({startOut, tripOut, blockedOut, startCount}, 0, "reset outputs");
        smp(1);
        chk(restrainedMode, 1, "restrained");
        pk(16'h03e8, 16'h0014);
        pk(16'h07d0, 16'h0014);
        pk(16'h1770, 16'h0046);
        pk(16'h2710, 16'h0078);
        pk(16'h2ee0, 16'h0078);
        grp = 3'h2;
        smp(1);
        chk(pickupLevelNow, 16'h0078, "group");
        load(16'h0014, 16'h0078, 16'h1f40, 16'h1f40, DLY_DT, 16'h0064);
        smp(1);
        chk(restrainedMode, 0, "controlled");
        pk(16'h1388, 16'h0014);
        pk(16'h1f40, 16'h0078);
        load(16'h0014, 16'h0078, 16'h07d0, 16'h2710, DLY_DT, 16'h0064);
        uS = 16'h03e8;
        $display("t_pick done");
    endtask

    task t_dt;
        grp = 3'h5;
        bS = 16'h001e;
        waitOn;
        {c0, s0} = {c1, s1};
        chk(b, 3'b001, "start");
        waitOn;
        chk(b, 3'b010, "trip");
        chk(c1 - c0 >= 400 && c1 - c0 <= 430, 1, "dt time");
        chk(s1 - s0 >= 100 && s1 - s0 <= 108, 1, "stamps");
        chk(prefaultCurrent, 16'h001e, "prefault");
        chk(ratioNow, 16'h0096, "ratio");
        bS = 16'h0014;
        smp(2);
        chk(tripOut, 1, "held at 100%");
        bS = 16'h0013;
        b = 3'b000;
        // Off pulses last one cycle, so gather them over two sample periods
        repeat (40)
        begin
            @(negedge sys_clk);
            b = b | eventOff;
        end
        chk(b, 3'b011, "off events");
        chk({startOut, tripOut}, 0, "drop");
        chk({startCount, tripCount}, 32'h00010001, "counts");
        rdIdx = 4'h0;
        repeat (2) @(negedge sys_clk);
        chk({recReadData[101:99], recReadData[2:0]}, 6'o15, "record 0");
        rdIdx = 4'h1;
        repeat (2) @(negedge sys_clk);
        chk({recReadData[101:99], recReadData[2:0]}, 6'o25, "record 1");
        cntClr = 1'b1;
        repeat (2) @(negedge sys_clk);
        cntClr = 1'b0;
        chk({startCount, tripCount}, 0, "clear");
        $display("t_dt done");
    endtask

    task t_inst_block;
        load(16'h0014, 16'h0078, 16'h07d0, 16'h2710, DLY_DT, 16'h0000);
        cS = 16'h001e;
        waitOn;
        chk(b, 3'b011, "instant");
        idle;
        load(16'h0014, 16'h0078, 16'h07d0, 16'h2710, DLY_DT, 16'h0064);
        blk = 1'b1;
        cS = 16'h001e;
        waitOn;
        chk({b, startOut}, 4'b1000, "blocked first");
        idle;
        cS = 16'h001e;
        waitOn;
        blk = 1'b1;
        waitOn;
        chk({b, startOut}, 4'b1000, "start reset");
        idle;
        chk({tripCount, blockedCount}, 32'h00010002, "block count");
        $display("t_inst_block done");
    endtask

    task t_idmt;
        load(16'h0014, 16'h0078, 16'h07d0, 16'h2710, DLY_IDMT, 16'h000a);
        for (int i = 0; i < 2; i++)
        begin
            aS = i ? 16'h0050 : 16'h0028;
            waitOn;
            c0 = c1;
            waitOn;
            // Ratio 2.00 gives 100 ms, ratio 4.00 gives 33 ms
            chk(c1 - c0 >= (i ? 132 : 400) && c1 - c0 <= (i ? 162 : 430), 1, "idmt");
            idle;
        end
        $display("t_idmt done");
    endtask

    task t_force;
        forceEn = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            ovr = vro_force_t'(i);
            repeat (3) @(negedge sys_clk);
            chk({blockedOut, tripOut, startOut}, 12'h8c8 >> (3 * i) & 7, "force");
        end
        forceEn = 1'b0;
        ovr = FORCE_TRIP;
        repeat (3) @(negedge sys_clk);
        chk({blockedOut, tripOut, startOut}, 0, "force off");
        $display("t_force done");
    endtask

    initial
    begin
        {reset_n, settingsLoad, blk, forceEn, cntClr, aS, bS, cS} = '0;
        {lc, hc, lv, hv, dly, mult} = {16'h0014, 16'h0078, 16'h07d0, 16'h2710, 16'h0064, 16'h0064};
        {uS, grp, rdIdx} = {16'h2710, 3'h1, 4'h0};
        md = DLY_DT;
        ovr = FORCE_NORMAL;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        t_pick;
        t_dt;
        t_inst_block;
        t_idmt;
        t_force;
        giveVerdict;
    end
endmodule
